// [verilog/tmr8_timer.sv]
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module tmr8_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire tmr8_pkg::tmr8_bus_t bus,
  output logic [7:0] rdata,
  // Core side
  input wire logic global_irq_en,
  input wire logic compare_vec_ack,
  input wire logic overflow_vec_ack,
  input wire logic wave_dir_bit,
  // Requests and pin
  output logic compare_irq,
  output logic overflow_irq,
  output tmr8_pkg::tmr8_pin_t wave_out
);

  typedef struct packed {
    tmr8_pkg::tmr8_ctl_t ctl;
    logic [7:0] cnt;
    logic [7:0] ocr_buf;
    logic [7:0] ocr_act;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [9:0] pre;
    tmr8_pkg::tmr8_dir_t dir;
    logic block;
    logic wave;
    logic [7:0] rdata;
  } tmr8_state_t;

  tmr8_state_t r;
  tmr8_state_t next_r;

  // Non-PWM action on a compare event
  function automatic logic act_plain(input logic [1:0] com, input logic cur);
    case (com)
      2'h1: return !cur;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
      default: return cur;
    endcase
  endfunction

  // PWM action; inv selects the bottom / down-count half
  function automatic logic act_pwm(input logic [1:0] com, input logic cur, input logic inv);
    return com[1] ? (com[0] ^ inv) : cur;
  endfunction

  function automatic logic is_pwm(input tmr8_pkg::tmr8_mode_t m);
    return (m == tmr8_pkg::MODE_PHASE) || (m == tmr8_pkg::MODE_FAST);
  endfunction

  tmr8_pkg::tmr8_mode_t mode;
  tmr8_pkg::tmr8_mode_t wr_mode;
  tmr8_pkg::tmr8_ctl_t wr_ctl;
  logic tick;
  logic match;
  logic special;
  logic force_apply;
  logic wr_ctl_hit;
  logic wr_cnt_hit;
  logic wr_cmp_hit;
  logic wr_flags_hit;
  logic [7:0] top;
  logic [1:0] set_flags;

  always_comb begin
    mode = tmr8_pkg::tmr8_mode_t'({r.ctl.wgm1, r.ctl.wgm0});
    wr_ctl = bus.wdata[6:0];
    wr_mode = tmr8_pkg::tmr8_mode_t'({wr_ctl.wgm1, wr_ctl.wgm0});
    wr_ctl_hit = bus.wr && (bus.addr == tmr8_pkg::ADDR_CTL);
    wr_cnt_hit = bus.wr && (bus.addr == tmr8_pkg::ADDR_CNT);
    wr_cmp_hit = bus.wr && (bus.addr == tmr8_pkg::ADDR_CMP);
    wr_flags_hit = bus.wr && (bus.addr == tmr8_pkg::ADDR_FLAGS);
    // Only the main clock feeds the prescaler here
    tick = tmr8_pkg::tmr8_tick(r.ctl.clk_select, r.pre); // [R13] [R20]
    top = (mode == tmr8_pkg::MODE_CLEAR) ? r.ocr_act : tmr8_pkg::CNT_MAX; // [R5]
    match = tick && (r.cnt == r.ocr_act) && !r.block; // [R15] [R14]
    special = is_pwm(mode) && (r.ocr_act == top) && r.ctl.out_action_sel[1]; // [R12]
    force_apply = wr_ctl_hit && bus.wdata[tmr8_pkg::FORCE_BIT] && !is_pwm(wr_mode); // [R1] [R4]
    set_flags = 2'h0;
    next_r = r;
    next_r.pre = r.pre + tmr8_pkg::ONE10;
    next_r.rdata = 8'h00;

    if (tick) begin // [R21]
      next_r.block = 1'b0;
      set_flags[tmr8_pkg::FLAG_CMP] = match; // [R18]
      case (mode)
        tmr8_pkg::MODE_NORMAL: begin
          next_r.cnt = r.cnt + tmr8_pkg::ONE8;
          set_flags[tmr8_pkg::FLAG_OVF] = (r.cnt == tmr8_pkg::CNT_MAX); // [R7]
          if (match) begin
            next_r.wave = act_plain(r.ctl.out_action_sel, r.wave); // [R9]
          end
        end
        tmr8_pkg::MODE_CLEAR: begin
          next_r.cnt = (r.cnt == top) ? tmr8_pkg::CNT_BOTTOM : r.cnt + tmr8_pkg::ONE8; // [R5]
          set_flags[tmr8_pkg::FLAG_OVF] = (r.cnt == tmr8_pkg::CNT_MAX); // [R7]
          if (match) begin
            next_r.wave = act_plain(r.ctl.out_action_sel, r.wave); // [R9]
          end
        end
        tmr8_pkg::MODE_FAST: begin
          next_r.cnt = r.cnt + tmr8_pkg::ONE8;
          set_flags[tmr8_pkg::FLAG_OVF] = (r.cnt == tmr8_pkg::CNT_MAX); // [R7]
          if (match && !special) begin
            next_r.wave = act_pwm(r.ctl.out_action_sel, r.wave, 1'b0); // [R10]
          end
          // TOP and the following BOTTOM share this tick
          if (r.cnt == tmr8_pkg::CNT_MAX) begin
            next_r.ocr_act = r.ocr_buf; // [R6]
            next_r.wave = act_pwm(r.ctl.out_action_sel, r.wave, 1'b1); // [R10] [R12]
          end
        end
        default: begin
          if (match && !special) begin
            next_r.wave = act_pwm(r.ctl.out_action_sel, r.wave,
                                  r.dir == tmr8_pkg::DIR_DOWN); // [R11]
          end
          if (r.dir == tmr8_pkg::DIR_UP) begin
            if (r.cnt == tmr8_pkg::CNT_MAX) begin
              next_r.dir = tmr8_pkg::DIR_DOWN;
              next_r.cnt = r.cnt - tmr8_pkg::ONE8;
              next_r.ocr_act = r.ocr_buf; // [R6]
              if (special) begin
                next_r.wave = act_pwm(r.ctl.out_action_sel, r.wave, 1'b1); // [R12]
              end
            end else begin
              next_r.cnt = r.cnt + tmr8_pkg::ONE8;
            end
          end else if (r.cnt == tmr8_pkg::CNT_BOTTOM) begin
            next_r.dir = tmr8_pkg::DIR_UP;
            next_r.cnt = r.cnt + tmr8_pkg::ONE8;
            set_flags[tmr8_pkg::FLAG_OVF] = 1'b1; // [R7]
          end else begin
            next_r.cnt = r.cnt - tmr8_pkg::ONE8;
          end
        end
      endcase
    end

    // Software writes take precedence over the tick's count and level
    if (wr_ctl_hit) begin
      next_r.ctl = wr_ctl;
      if (!is_pwm(wr_mode)) begin
        next_r.dir = tmr8_pkg::DIR_UP;
      end
      if (force_apply) begin
        next_r.wave = act_plain(wr_ctl.out_action_sel, next_r.wave); // [R1] [R2]
      end
    end else if (wr_cnt_hit) begin
      next_r.cnt = bus.wdata; // [R14]
      next_r.block = 1'b1; // [R14]
    end else if (wr_cmp_hit) begin
      next_r.ocr_buf = bus.wdata;
      if (!is_pwm(mode)) begin
        next_r.ocr_act = bus.wdata; // [R6]
      end
    end else if (wr_flags_hit) begin
      next_r.flags = r.flags & ~bus.wdata[1:0]; // [R18] [R19]
    end else if (bus.wr && (bus.addr == tmr8_pkg::ADDR_MASK)) begin
      next_r.mask = bus.wdata[1:0];
    end

    if (compare_vec_ack) begin
      next_r.flags[tmr8_pkg::FLAG_CMP] = 1'b0; // [R18]
    end
    if (overflow_vec_ack) begin
      next_r.flags[tmr8_pkg::FLAG_OVF] = 1'b0; // [R19]
    end
    // A hardware set in the clearing cycle wins
    next_r.flags = next_r.flags | set_flags; // [R18] [R19]

    if (bus.rd) begin
      if (bus.addr == tmr8_pkg::ADDR_CTL) begin
        next_r.rdata = {1'b0, r.ctl}; // [R3]
      end else if (bus.addr == tmr8_pkg::ADDR_CNT) begin
        next_r.rdata = r.cnt; // [R14]
      end else if (bus.addr == tmr8_pkg::ADDR_CMP) begin
        next_r.rdata = r.ocr_buf;
      end else if (bus.addr == tmr8_pkg::ADDR_FLAGS) begin
        next_r.rdata = {6'h00, r.flags};
      end else if (bus.addr == tmr8_pkg::ADDR_MASK) begin
        next_r.rdata = {6'h00, r.mask};
      end else begin
        next_r.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '{ctl: '0, cnt: 8'h00, ocr_buf: 8'h00, ocr_act: 8'h00, flags: 2'h0,
             mask: 2'h0, pre: 10'h000, dir: tmr8_pkg::DIR_UP, block: 1'b0,
             wave: 1'b0, rdata: 8'h00};
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign compare_irq = r.flags[tmr8_pkg::FLAG_CMP] && r.mask[tmr8_pkg::FLAG_CMP]
                       && global_irq_en; // [R16]
  assign overflow_irq = r.flags[tmr8_pkg::FLAG_OVF] && r.mask[tmr8_pkg::FLAG_OVF]
                        && global_irq_en; // [R17]
  // One driver for the whole pin bundle
  assign wave_out = '{level: r.wave, oe: (|r.ctl.out_action_sel) && wave_dir_bit,
                      override_en: |r.ctl.out_action_sel}; // [R8]

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_force_write;
    force_apply && !tick && !compare_vec_ack;
  endsequence

  sequence s_flag_held;
    r.flags[tmr8_pkg::FLAG_CMP] == $past(r.flags[tmr8_pkg::FLAG_CMP]);
  endsequence

  property p_force_no_flag;
    s_force_write |=> s_flag_held;
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("forced compare set flag"); // [R2]

  property p_force_no_clear;
    (s_force_write and !r.block) |=> r.cnt == $past(r.cnt);
  endproperty
  a_force_no_clear: assert property (p_force_no_clear) else $error("forced compare moved counter"); // [R2]

  property p_force_readback;
    bus.rd && bus.addr == tmr8_pkg::ADDR_CTL |=> !rdata[tmr8_pkg::FORCE_BIT];
  endproperty
  a_force_readback: assert property (p_force_readback) else $error("force bit read as one"); // [R3]

  property p_clear_top;
    tick && mode == tmr8_pkg::MODE_CLEAR && r.cnt == r.ocr_act && !bus.wr
      |=> r.cnt == tmr8_pkg::CNT_BOTTOM;
  endproperty
  a_clear_top: assert property (p_clear_top) else $error("counter not cleared at compare top"); // [R5]

  property p_ocr_now;
    wr_cmp_hit && !is_pwm(mode) |=> r.ocr_act == $past(bus.wdata);
  endproperty
  a_ocr_now: assert property (p_ocr_now) else $error("compare not loaded at once"); // [R6]

  property p_ovf_max;
    tick && mode == tmr8_pkg::MODE_NORMAL && r.cnt == tmr8_pkg::CNT_MAX
      |=> r.flags[tmr8_pkg::FLAG_OVF];
  endproperty
  a_ovf_max: assert property (p_ovf_max) else $error("overflow flag missed at MAX"); // [R7]

  property p_override;
    wr_ctl_hit |=> wave_out.override_en == ($past(wr_ctl.out_action_sel) != 2'h0)
      && wave_out.oe == (wave_out.override_en && wave_dir_bit);
  endproperty
  a_override: assert property (p_override) else $error("pin driven while disconnected"); // [R8]

  property p_toggle;
    match && mode == tmr8_pkg::MODE_NORMAL && r.ctl.out_action_sel == 2'h1 && !bus.wr
      |=> wave_out.level != $past(wave_out.level);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match failed"); // [R9]

  property p_fast_bottom;
    tick && mode == tmr8_pkg::MODE_FAST && r.ctl.out_action_sel == 2'h2
      && r.cnt == tmr8_pkg::CNT_MAX && !bus.wr |=> wave_out.level;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast PWM not set at BOTTOM"); // [R10]

  property p_stopped;
    r.ctl.clk_select == 3'h0 && !bus.wr |=> r.cnt == $past(r.cnt);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved"); // [R13]

  property p_blocked;
    tick && r.block && !r.flags[tmr8_pkg::FLAG_CMP] |=> !r.flags[tmr8_pkg::FLAG_CMP];
  endproperty
  a_blocked: assert property (p_blocked) else $error("match after counter write"); // [R14]

  property p_set_wins;
    match && (compare_vec_ack || wr_flags_hit) |=> r.flags[tmr8_pkg::FLAG_CMP] [*1] ##1 1'b1;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("compare flag lost on clear"); // [R18]

endmodule
`default_nettype wire

// [verilog/tmr8_pkg.sv]
// How it works
// [R1] Force strobe in non-PWM mode applies an immediate compare action to the output.
// [R2] Forced compare sets no flag, raises no interrupt, never clears the counter.
// [R3] Force strobe bit always reads back as zero.
// [R4] Software writes force strobe as zero while a PWM mode is selected.
// [R5] Mode code: 0 normal, 1 phase-correct PWM, 2 clear-on-compare, 3 fast PWM.
// [R6] Active compare loads at once in non-PWM, at TOP phase-correct, BOTTOM fast.
// [R7] Overflow flag set at MAX, or at direction change at zero in phase-correct.
// [R8] Nonzero output action overrides the pin; driver enabled only with direction bit.
// [R9] Non-PWM actions on match: 00 off, 01 toggle, 10 clear, 11 set.
// [R10] Fast PWM: 10 clears on match and sets at BOTTOM, 11 inverse.
// [R11] Phase-correct: 10 clears on up-count match, sets on down-count match; 11 inverse.
// [R12] PWM with compare equal TOP and upper action bit: skip match, act at TOP.
// [R13] Clock select: stop, undivided, or source divided by 8 to 1024.
// [R14] Counter readable and writable; a write blocks the match on the next tick.
// [R15] Compare register is checked against the counter all the time; here it is compared only on tick cycles.
// [R16] Compare request when compare flag, its enable and global enable are all set.
// [R17] Overflow request when overflow flag, its enable and global enable are all set.
// [R18] Compare flag set on match; cleared by vector execution or writing one.
// [R19] Overflow flag cleared by vector execution or writing one; zero leaves it.
// [R20] Timer source clock is the main clock.
// [R21] Counter, compare and flags advance only on prescaled tick cycles.
`default_nettype none
package tmr8_pkg;
  localparam logic [7:0] ADDR_CTL = 8'hB0;
  localparam logic [7:0] ADDR_CNT = 8'hB2;
  localparam logic [7:0] ADDR_CMP = 8'hB3;
  localparam logic [7:0] ADDR_MASK = 8'h70;
  localparam logic [7:0] ADDR_FLAGS = 8'h37;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [9:0] ONE10 = 10'h001;
  localparam int FORCE_BIT = 7;
  localparam int FLAG_CMP = 1;
  localparam int FLAG_OVF = 0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PHASE = 2'h1,
    MODE_CLEAR = 2'h2,
    MODE_FAST = 2'h3
  } tmr8_mode_t;

  typedef enum logic [1:0] {
    DIR_UP = 2'h1,
    DIR_DOWN = 2'h2
  } tmr8_dir_t;

  // Byte layout of the control register, force strobe excluded
  typedef struct packed {
    logic wgm0;
    logic [1:0] out_action_sel;
    logic wgm1;
    logic [2:0] clk_select;
  } tmr8_ctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr8_bus_t;

  typedef struct packed {
    logic level;
    logic oe;
    logic override_en;
  } tmr8_pin_t;

  // Divider taps on the free prescaler count
  function automatic logic tmr8_tick(input logic [2:0] sel, input logic [9:0] pre);
    logic [9:0] m;
    m = 10'h000;
    case (sel)
      3'h2: m = 10'h007;
      3'h3: m = 10'h01F;
      3'h4: m = 10'h03F;
      3'h5: m = 10'h07F;
      3'h6: m = 10'h0FF;
      3'h7: m = 10'h3FF;
      default: m = 10'h000;
    endcase
    if (sel == 3'h0) begin
      return 1'b0;
    end
    return (pre & m) == m;
  endfunction
endpackage
`default_nettype wire

// [tb/test_timer8_compare_pwm.sv]
`timescale 1ns/1ns
`default_nettype none
module test_timer8_compare_pwm;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  tmr8_pkg::tmr8_bus_t bus = '0;
  logic gie = 1'b0;
  logic ack_c = 1'b0;
  logic ack_o = 1'b0;
  logic dir = 1'b0;
  logic [7:0] rdata;
  logic cirq;
  logic oirq;
  tmr8_pkg::tmr8_pin_t wave;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 4;
  int hi;
  int div;
  logic [15:0] q[$];
  logic [15:0] e;
  logic rd_seen = 1'b0;
  logic [7:0] last;
  logic [7:0] v;
  logic lvl;
  localparam logic [7:0] ADRS [6] = '{8'hB0, 8'hB2, 8'hB3, 8'h70, 8'h37, 8'hB1};

  tmr8_timer i_dut (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata),
    .global_irq_en(gie), .compare_vec_ack(ack_c), .overflow_vec_ack(ack_o),
    .wave_dir_bit(dir), .compare_irq(cirq), .overflow_irq(oirq), .wave_out(wave));

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic print_verdict;
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] ctl(input logic f, input logic [1:0] m,
                                     input logic [1:0] a, input logic [2:0] cs);
    return {f, m[0], a, m[1], cs};
  endfunction

  // One bus assignment per cycle, so back-to-back accesses never double-drive
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    q.push_back({m, x});
    op(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clock);
  endtask

  // Masked entries capture values whose exact count is timing-dependent
  always @(posedge clock) begin
    if (rd_seen) begin
      last = rdata;
      e = q.pop_front();
      check("rdata", rdata & e[15:8], e[7:0]);
    end
    rd_seen <= bus.rd;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic duty(input logic [1:0] m, input logic [1:0] a, input logic [7:0] c,
                      input int lo, input int up);
    wr(8'hB3, c);
    wr(8'hB0, ctl(1'b0, m, a, 3'h1));
    idle(600);
    hi = 0;
    repeat (1024) begin
      @(posedge clock);
      hi += (wave.level === 1'b1);
    end
    check("duty_in_range", hi >= lo && hi <= up, 1'b1);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 6; i++) rd(ADRS[i], 8'h00, 8'hFF);
    v = $random(seed);
    wr(8'hB2, v);
    rd(8'hB2, v, 8'hFF);
    wr(8'hB3, ~v);
    rd(8'hB3, ~v, 8'hFF);
    wr(8'h70, 8'hFF);
    rd(8'h70, 8'h03, 8'hFF);
    wr(8'hB1, 8'h5A);
    rd(8'hB1, 8'h00, 8'hFF);
    dir <= 1'b1;
    lvl = 1'b0;
    for (int i = 1; i < 4; i++) begin
      wr(8'hB0, ctl(1'b1, tmr8_pkg::MODE_NORMAL, i[1:0], 3'h0));
      rd(8'hB0, ctl(1'b0, tmr8_pkg::MODE_NORMAL, i[1:0], 3'h0), 8'hFF);
      idle(2);
      lvl = (i == 1) ? ~lvl : i[0];
      check("wave_level", wave.level, lvl);
      check("wave_oe", {wave.override_en, wave.oe}, 2'h3);
    end
    dir <= 1'b0;
    rd(8'h37, 8'h00, 8'hFF);
    idle(1);
    check("wave_oe", {wave.override_en, wave.oe}, 2'h2);
    wr(8'hB2, 8'h33);
    wr(8'hB0, ctl(1'b1, tmr8_pkg::MODE_CLEAR, 2'h2, 3'h0));
    rd(8'hB2, 8'h33, 8'hFF);
    wr(8'hB0, ctl(1'b1, tmr8_pkg::MODE_FAST, 2'h3, 3'h0));
    idle(2);
    check("wave_level", wave.level, 1'b0);
    // Short period in clear-on-compare keeps the count away from MAX
    gie <= 1'b1;
    // Leave PWM first, or the compare write only reaches the buffer
    wr(8'hB0, ctl(1'b0, tmr8_pkg::MODE_CLEAR, 2'h1, 3'h0));
    wr(8'hB3, 8'h04);
    wr(8'hB2, 8'h00);
    wr(8'h37, 8'h03);
    wr(8'hB0, ctl(1'b0, tmr8_pkg::MODE_CLEAR, 2'h1, 3'h1));
    idle(40);
    check("compare_irq", cirq, 1'b1);
    check("overflow_irq", oirq, 1'b0);
    wr(8'hB0, ctl(1'b0, tmr8_pkg::MODE_CLEAR, 2'h1, 3'h0));
    rd(8'hB2, 8'h00, 8'hF8);
    wr(8'h70, 8'h01);
    idle(1);
    check("compare_irq", cirq, 1'b0);
    gie <= 1'b0;
    wr(8'h70, 8'h02);
    idle(1);
    check("compare_irq", cirq, 1'b0);
    gie <= 1'b1;
    wr(8'h37, 8'h00);
    rd(8'h37, 8'h02, 8'hFF);
    wr(8'h37, 8'h02);
    rd(8'h37, 8'h00, 8'hFF);
    wr(8'h70, 8'h01);
    wr(8'hB0, ctl(1'b0, tmr8_pkg::MODE_NORMAL, 2'h0, 3'h1));
    idle(300);
    check("overflow_irq", oirq, 1'b1);
    wr(8'hB0, 8'h00);
    wr(8'h37, 8'h00);
    rd(8'h37, 8'h03, 8'hFF);
    ack_c <= 1'b1;
    ack_o <= 1'b1;
    idle(1);
    ack_c <= 1'b0;
    ack_o <= 1'b0;
    rd(8'h37, 8'h00, 8'hFF);
    idle(1);
    check("overflow_irq", oirq, 1'b0);
    // Counter write blocks the match that follows it
    wr(8'hB2, 8'h80);
    wr(8'h37, 8'h03);
    wr(8'hB0, ctl(1'b0, tmr8_pkg::MODE_NORMAL, 2'h0, 3'h1));
    wr(8'hB2, 8'h04);
    idle(3);
    rd(8'h37, 8'h00, 8'h02);
    idle(260);
    rd(8'h37, 8'h02, 8'h02);
    div = 8;
    // A free prescaler gives exactly four ticks in four periods
    for (int cs = 2; cs < 8; cs++) begin
      wr(8'hB0, ctl(1'b0, tmr8_pkg::MODE_NORMAL, 2'h0, cs[2:0]));
      wr(8'hB2, 8'h00);
      idle(4 * div);
      rd(8'hB2, 8'h00, 8'h00);
      idle(2);
      check("ticks_in_window", last, 8'h04);
      div = (cs == 6) ? 1024 : div * ((cs == 2) ? 4 : 2);
    end
    duty(tmr8_pkg::MODE_FAST, 2'h2, 8'h40, 254, 266);
    duty(tmr8_pkg::MODE_FAST, 2'h3, 8'h40, 758, 770);
    duty(tmr8_pkg::MODE_PHASE, 2'h2, 8'h40, 250, 264);
    duty(tmr8_pkg::MODE_PHASE, 2'h3, 8'h40, 760, 774);
    duty(tmr8_pkg::MODE_FAST, 2'h2, 8'hFF, 1024, 1024);
    duty(tmr8_pkg::MODE_PHASE, 2'h3, 8'hFF, 0, 0);
    idle(2);
    print_verdict();
  end
endmodule
`default_nettype wire
